// >>> src/quf_quad_uart.sv
// Operation
// R1: Host configures the device with 8-bit register words over its bus port.
// R2: Four identical independent channels, each with transmitter, receiver and two queues.
// R3: Transmit holding writes enter the queue, get framed and are shifted out.
// R4: Start is a falling input edge; line sampled sixteen times per bit normally.
// R5: Transmit and receive queues each hold up to 128 words.
// R6: Trigger thresholds programmable in steps of eight, able to flag the host.
// R7: Four-bit transmit threshold; fill level reaching it sets cause bit 4.
// R8: Receive trigger shows the receive queue holds the programmed word count.
// R9: Host can read both queue fill counts at any time.
// R10: Cause bit 5 rises when the transmitter starts the last queued word.
// R11: Line stays busy one full character after cause bit 5 sets.
// R12: Queue clear bit in second mode register empties both queues.
// R13: Transmit halt finishes the current character then stops sending.
// R14: Infrared control bit 5 inverts serial output; zero means normal.
// R15: Idle line high, low first bit is start, bits judged near midbit.
// R16: Each received word is stored together with its own status bits.
// R17: Receive reads return oldest first; line status shows that word's status.
// R18: Parity, framing and noise determined per word; noise from three samples.
// R19: Receive halt stops after the current word and accepts nothing more.
// R20: Infrared control bit 4 inverts serial input before reception.
// R21: Standard or double rate: disagreeing samples set line status bit 5.
// R22: Quadruple rate takes one midbit sample per bit and does no voting.
// R23: Baud config bits 5:4 select standard, double or quadruple rate.
// R24: Writes to a full transmit queue and reads of an empty receive queue are ignored.
// R25: Queues, status and control reset to empty and inactive.
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module quf_quad_uart #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sampleClk,
   input wire logic [quf_pkg::NUM_CHAN-1:0] rxd,
   output wire logic [quf_pkg::NUM_CHAN-1:0] txd,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic awHeld_q;
   logic wHeld_q;
   logic [ADDR_W-1:0] awAddr_q;
   logic [7:0] wData_q;
   logic wLane0_q;
   logic doWrite;
   logic arFire;
   logic [quf_pkg::NUM_CHAN-1:0][7:0] chanRd;
   logic [7:0] rdSel;
   logic smp1_q;
   logic smp2_q;
   logic smp3_q;
   logic tick;

   function automatic logic isMapped(input logic [5:0] ofs);
      isMapped = (ofs <= quf_pkg::OFS_INVERT) && (ofs[1:0] == 2'h0);
   endfunction : isMapped

   assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
   assign arFire = s_axi_arvalid && s_axi_arready;
   assign rdSel = chanRd[s_axi_araddr[7:6]];

   // Write channel: address and data are taken in either order, one write in flight. [R1]
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= '0;
         wData_q <= 8'h00;
         wLane0_q <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= quf_pkg::AXI_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata[7:0];
            wLane0_q <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= isMapped(awAddr_q[5:0]) ? quf_pkg::AXI_OKAY : quf_pkg::AXI_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Read channel: data is captured at the address handshake, so a pop happens exactly once.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= quf_pkg::AXI_OKAY;
      end else if (arFire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rdSel};
         s_axi_rresp <= isMapped(s_axi_araddr[5:0]) ? quf_pkg::AXI_OKAY : quf_pkg::AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Sample clock crosses in through two flops; its rising edge is one tick.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         smp1_q <= 1'b0;
         smp2_q <= 1'b0;
         smp3_q <= 1'b0;
      end else begin
         smp1_q <= sampleClk;
         smp2_q <= smp1_q;
         smp3_q <= smp2_q;
      end
   end
   assign tick = smp2_q && !smp3_q;

   // One identical channel per iteration. [R2]
   for (genvar g = 0; g < quf_pkg::NUM_CHAN; g++) begin : gChan
      logic [7:0] first_mode_reg_q;
      logic [7:0] second_mode_reg_q;
      logic [7:0] trig_q;
      logic [7:0] cfg_q;
      logic [7:0] baud_q;
      logic [7:0] inv_q;
      logic [7:0] lsr_q;
      logic [7:0] irq_q;
      logic [7:0] txMem_q [quf_pkg::FIFO_DEPTH];
      quf_pkg::quf_rx_word_type rxMem_q [quf_pkg::FIFO_DEPTH];
      logic [quf_pkg::PTR_W-1:0] txWr_q, txRd_q, rxWr_q, rxRd_q;
      logic [quf_pkg::LVL_W-1:0] txCnt_q, rxCnt_q;
      logic wrHit, rdHit, fifoClear, txPush, txPop, rxPush, rxPop;
      logic [7:0] rdVal;
      logic [3:0] lastTick, midTick;
      logic quadMode;
      quf_pkg::quf_ser_state_type txState_q, rxState_q;
      logic [3:0] txTick_q, rxTick_q;
      logic [2:0] txBit_q, rxBit_q;
      logic [7:0] txShift_q, rxShift_q;
      logic txPar_q, txLine_q, txRaw;
      logic rxs1_q, rxs2_q, rxPrev_q;
      logic rxIn, rxBitEnd, voteBit, voteNoise;
      logic [2:0] rxSamp_q;
      logic line_noise_flag_q, rxParErr_q;
      quf_pkg::quf_rx_word_type rxWord;

      assign wrHit = doWrite && wLane0_q && (awAddr_q[7:6] == g);
      assign rdHit = arFire && (s_axi_araddr[7:6] == g);
      assign fifoClear = second_mode_reg_q[quf_pkg::SECOND_MODE_REG_CLEAR_BIT]; // [R12]
      assign txPush = wrHit && (awAddr_q[5:0] == quf_pkg::OFS_DATA)
         && (txCnt_q != quf_pkg::FIFO_FULL_LVL) && !fifoClear; // [R3] [R24]
      assign rxPop = rdHit && (s_axi_araddr[5:0] == quf_pkg::OFS_DATA)
         && (rxCnt_q != '0) && !fifoClear; // [R17] [R24]
      assign txPop = (txState_q == quf_pkg::SER_IDLE) && (txCnt_q != '0)
         && !first_mode_reg_q[quf_pkg::FIRST_MODE_REG_TX_HALT_BIT] && !fifoClear; // [R13]

      // Control registers written by software. [R1] [R25]
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            first_mode_reg_q <= quf_pkg::REG_RESET;
            second_mode_reg_q <= quf_pkg::REG_RESET;
            trig_q <= quf_pkg::REG_RESET;
            cfg_q <= quf_pkg::REG_RESET;
            baud_q <= quf_pkg::REG_RESET;
            inv_q <= quf_pkg::REG_RESET;
         end else if (wrHit) begin
            if (awAddr_q[5:0] == quf_pkg::OFS_FIRST_MODE_REG) begin
               first_mode_reg_q <= wData_q;
            end else if (awAddr_q[5:0] == quf_pkg::OFS_SECOND_MODE_REG) begin
               second_mode_reg_q <= wData_q;
            end else if (awAddr_q[5:0] == quf_pkg::OFS_TRIG) begin
               trig_q <= wData_q; // [R6]
            end else if (awAddr_q[5:0] == quf_pkg::OFS_LINECFG) begin
               cfg_q <= wData_q;
            end else if (awAddr_q[5:0] == quf_pkg::OFS_BAUD) begin
               baud_q <= wData_q; // [R23]
            end else if (awAddr_q[5:0] == quf_pkg::OFS_INVERT) begin
               inv_q <= wData_q;
            end
         end
      end

      always_comb begin
         rdVal = 8'h00;
         if (s_axi_araddr[5:0] == quf_pkg::OFS_DATA) begin
            rdVal = (rxCnt_q != '0) ? rxMem_q[rxRd_q].data : 8'h00;
         end else if (s_axi_araddr[5:0] == quf_pkg::OFS_FIRST_MODE_REG) begin
            rdVal = first_mode_reg_q;
         end else if (s_axi_araddr[5:0] == quf_pkg::OFS_SECOND_MODE_REG) begin
            rdVal = second_mode_reg_q;
         end else if (s_axi_araddr[5:0] == quf_pkg::OFS_LSR) begin
            rdVal = lsr_q;
         end else if (s_axi_araddr[5:0] == quf_pkg::OFS_IRQ) begin
            rdVal = irq_q;
         end else if (s_axi_araddr[5:0] == quf_pkg::OFS_TRIG) begin
            rdVal = trig_q;
         end else if (s_axi_araddr[5:0] == quf_pkg::OFS_TXLVL) begin
            rdVal = txCnt_q; // [R9]
         end else if (s_axi_araddr[5:0] == quf_pkg::OFS_RXLVL) begin
            rdVal = rxCnt_q; // [R9]
         end else if (s_axi_araddr[5:0] == quf_pkg::OFS_LINECFG) begin
            rdVal = cfg_q;
         end else if (s_axi_araddr[5:0] == quf_pkg::OFS_BAUD) begin
            rdVal = baud_q;
         end else if (s_axi_araddr[5:0] == quf_pkg::OFS_INVERT) begin
            rdVal = inv_q;
         end
      end
      assign chanRd[g] = rdVal;

      // Cause bits clear on read, but a set in the same cycle wins. [R6] [R7] [R8] [R10]
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            irq_q <= quf_pkg::REG_RESET;
         end else begin
            if (rdHit && (s_axi_araddr[5:0] == quf_pkg::OFS_IRQ)) begin
               irq_q <= quf_pkg::REG_RESET;
            end
            if ((trig_q[3:0] != 4'h0) && (txCnt_q >= {1'b0, trig_q[3:0], 3'b000})) begin
               irq_q[quf_pkg::IRQ_TX_TRIG_BIT] <= 1'b1; // [R7]
            end
            if ((trig_q[7:4] != 4'h0) && (rxCnt_q >= {1'b0, trig_q[7:4], 3'b000})) begin
               irq_q[quf_pkg::IRQ_RX_TRIG_BIT] <= 1'b1; // [R8]
            end
            if (txPop && (txCnt_q == 8'h01) && !txPush) begin
               irq_q[quf_pkg::IRQ_TX_EMPTY_BIT] <= 1'b1; // [R10]
            end
         end
      end

      // Queue storage needs no reset; pointers and counts carry the state. [R5]
      always_ff @(posedge clk) begin
         if (txPush) begin
            txMem_q[txWr_q] <= wData_q;
         end
         if (rxPush) begin
            rxMem_q[rxWr_q] <= rxWord; // [R16]
         end
      end

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            txWr_q <= '0;
            txRd_q <= '0;
            txCnt_q <= '0;
            rxWr_q <= '0;
            rxRd_q <= '0;
            rxCnt_q <= '0;
            lsr_q <= quf_pkg::REG_RESET;
         end else if (fifoClear) begin
            txWr_q <= '0;
            txRd_q <= '0;
            txCnt_q <= '0;
            rxWr_q <= '0;
            rxRd_q <= '0;
            rxCnt_q <= '0; // [R12]
         end else begin
            txWr_q <= txWr_q + PTR_ONE(txPush);
            txRd_q <= txRd_q + PTR_ONE(txPop);
            txCnt_q <= txCnt_q + LVL_ONE(txPush) - LVL_ONE(txPop);
            rxWr_q <= rxWr_q + PTR_ONE(rxPush);
            rxRd_q <= rxRd_q + PTR_ONE(rxPop);
            rxCnt_q <= rxCnt_q + LVL_ONE(rxPush) - LVL_ONE(rxPop);
            if (rxPop) begin
               lsr_q <= 8'h00;
               lsr_q[quf_pkg::LSR_PARITY_BIT] <= rxMem_q[rxRd_q].parity;
               lsr_q[quf_pkg::LSR_FRAME_BIT] <= rxMem_q[rxRd_q].frame;
               lsr_q[quf_pkg::LSR_NOISE_BIT] <= rxMem_q[rxRd_q].noise; // [R17] [R21]
            end
         end
      end

      always_comb begin
         quadMode = 1'b0;
         lastTick = quf_pkg::LAST_TICK_STD;
         midTick = quf_pkg::MID_TICK_STD; // [R4]
         if (baud_q[quf_pkg::BAUD_RATE_LSB +: 2] == quf_pkg::RATE_DBL) begin
            lastTick = quf_pkg::LAST_TICK_DBL;
            midTick = quf_pkg::MID_TICK_DBL;
         end else if (baud_q[quf_pkg::BAUD_RATE_LSB +: 2] != quf_pkg::RATE_STD) begin
            quadMode = 1'b1;
            lastTick = quf_pkg::LAST_TICK_QUAD;
            midTick = quf_pkg::MID_TICK_QUAD; // [R23]
         end
      end

      // Transmitter; the last word is framed in full after the empty flag sets. [R3] [R11]
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            txState_q <= quf_pkg::SER_IDLE;
            txTick_q <= 4'h0;
            txBit_q <= 3'h0;
            txShift_q <= 8'h00;
            txPar_q <= 1'b0;
         end else if (txPop) begin
            txState_q <= quf_pkg::SER_START;
            txTick_q <= 4'h0;
            txShift_q <= txMem_q[txRd_q];
            txPar_q <= ^txMem_q[txRd_q] ^ !cfg_q[quf_pkg::CFG_PAR_EVEN_BIT];
         end else if (tick && (txState_q != quf_pkg::SER_IDLE)) begin
            txTick_q <= txTick_q + 4'h1;
            if (txTick_q >= lastTick) begin
               txTick_q <= 4'h0;
               case (txState_q)
                  quf_pkg::SER_START: begin
                     txState_q <= quf_pkg::SER_DATA;
                     txBit_q <= 3'h0;
                  end
                  quf_pkg::SER_DATA: begin
                     txShift_q <= {1'b0, txShift_q[7:1]};
                     txBit_q <= txBit_q + 3'h1;
                     if (txBit_q == quf_pkg::LAST_DATA_BIT) begin
                        txState_q <= cfg_q[quf_pkg::CFG_PAR_EN_BIT] ?
                           quf_pkg::SER_PARITY : quf_pkg::SER_STOP;
                     end
                  end
                  quf_pkg::SER_PARITY: begin
                     txState_q <= quf_pkg::SER_STOP;
                  end
                  default: begin
                     txState_q <= quf_pkg::SER_IDLE;
                  end
               endcase
            end
         end
      end

      always_comb begin
         case (txState_q)
            quf_pkg::SER_START: txRaw = 1'b0;
            quf_pkg::SER_DATA: txRaw = txShift_q[0];
            quf_pkg::SER_PARITY: txRaw = txPar_q;
            default: txRaw = 1'b1;
         endcase
      end

      // The pin is registered so it leaves the block glitch-free. [R14]
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            txLine_q <= 1'b1;
         end else begin
            txLine_q <= txRaw ^ inv_q[quf_pkg::INV_TX_BIT];
         end
      end
      assign txd[g] = txLine_q;

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            rxs1_q <= 1'b1;
            rxs2_q <= 1'b1;
         end else begin
            rxs1_q <= rxd[g];
            rxs2_q <= rxs1_q;
         end
      end
      assign rxIn = rxs2_q ^ inv_q[quf_pkg::INV_RX_BIT]; // [R20]

      always_comb begin
         voteBit = (rxSamp_q[0] & rxSamp_q[1]) | (rxSamp_q[0] & rxSamp_q[2])
            | (rxSamp_q[1] & rxSamp_q[2]);
         voteNoise = !((rxSamp_q == 3'b000) || (rxSamp_q == 3'b111)); // [R18] [R21]
         if (quadMode) begin
            voteBit = rxSamp_q[1];
            voteNoise = 1'b0; // [R22]
         end
         rxWord.noise = line_noise_flag_q;
         rxWord.parity = rxParErr_q;
         rxWord.frame = !voteBit;
         rxWord.data = rxShift_q;
      end
      assign rxBitEnd = tick && (rxTick_q >= lastTick);
      assign rxPush = rxBitEnd && (rxState_q == quf_pkg::SER_STOP)
         && (rxCnt_q != quf_pkg::FIFO_FULL_LVL) && !fifoClear;

      // Receiver: falling edge starts a frame, samples around midbit decide each bit. [R4] [R15]
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            rxState_q <= quf_pkg::SER_IDLE;
            rxTick_q <= 4'h0;
            rxBit_q <= 3'h0;
            rxShift_q <= 8'h00;
            rxSamp_q <= 3'h0;
            rxPrev_q <= 1'b1;
            line_noise_flag_q <= 1'b0;
            rxParErr_q <= 1'b0;
         end else if (tick) begin
            rxPrev_q <= rxIn;
            rxTick_q <= rxTick_q + 4'h1;
            if (rxTick_q == midTick - 4'h1) begin
               rxSamp_q[0] <= rxIn;
            end
            if (rxTick_q == midTick) begin
               rxSamp_q[1] <= rxIn;
            end
            if (rxTick_q == midTick + 4'h1) begin
               rxSamp_q[2] <= rxIn;
            end
            if (rxState_q == quf_pkg::SER_IDLE) begin
               rxTick_q <= 4'h1;
               line_noise_flag_q <= 1'b0;
               rxParErr_q <= 1'b0;
               if (rxPrev_q && !rxIn && !first_mode_reg_q[quf_pkg::FIRST_MODE_REG_RX_HALT_BIT]) begin
                  rxState_q <= quf_pkg::SER_START; // [R19]
               end
            end else if (rxTick_q >= lastTick) begin
               rxTick_q <= 4'h0;
               line_noise_flag_q <= line_noise_flag_q | voteNoise;
               case (rxState_q)
                  quf_pkg::SER_START: begin
                     rxBit_q <= 3'h0;
                     rxState_q <= voteBit ? quf_pkg::SER_IDLE : quf_pkg::SER_DATA;
                  end
                  quf_pkg::SER_DATA: begin
                     rxShift_q <= {voteBit, rxShift_q[7:1]};
                     rxBit_q <= rxBit_q + 3'h1;
                     if (rxBit_q == quf_pkg::LAST_DATA_BIT) begin
                        rxState_q <= cfg_q[quf_pkg::CFG_PAR_EN_BIT] ?
                           quf_pkg::SER_PARITY : quf_pkg::SER_STOP;
                     end
                  end
                  quf_pkg::SER_PARITY: begin
                     rxParErr_q <= voteBit !=
                        (^rxShift_q ^ !cfg_q[quf_pkg::CFG_PAR_EVEN_BIT]); // [R18]
                     rxState_q <= quf_pkg::SER_STOP;
                  end
                  default: begin
                     rxState_q <= quf_pkg::SER_IDLE; // [R16]
                  end
               endcase
            end
         end
      end
   end

   function automatic logic [quf_pkg::PTR_W-1:0] PTR_ONE(input logic en);
      PTR_ONE = {{(quf_pkg::PTR_W-1){1'b0}}, en};
   endfunction : PTR_ONE

   function automatic logic [quf_pkg::LVL_W-1:0] LVL_ONE(input logic en);
      LVL_ONE = {{(quf_pkg::LVL_W-1){1'b0}}, en};
   endfunction : LVL_ONE
endmodule : quf_quad_uart

// >>> src/quf_pkg.sv
package quf_pkg;
   localparam int NUM_CHAN = 4;
   localparam int FIFO_DEPTH = 128;
   localparam int PTR_W = 7;
   localparam int LVL_W = 8;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [LVL_W-1:0] FIFO_FULL_LVL = 8'h80;
   // Byte offsets inside one channel window; channel number sits in address bits 7:6.
   localparam logic [5:0] OFS_DATA = 6'h00;
   localparam logic [5:0] OFS_FIRST_MODE_REG = 6'h04;
   localparam logic [5:0] OFS_SECOND_MODE_REG = 6'h08;
   localparam logic [5:0] OFS_LSR = 6'h0C;
   localparam logic [5:0] OFS_IRQ = 6'h10;
   localparam logic [5:0] OFS_TRIG = 6'h14;
   localparam logic [5:0] OFS_TXLVL = 6'h18;
   localparam logic [5:0] OFS_RXLVL = 6'h1C;
   localparam logic [5:0] OFS_LINECFG = 6'h20;
   localparam logic [5:0] OFS_BAUD = 6'h24;
   localparam logic [5:0] OFS_INVERT = 6'h28;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   localparam int FIRST_MODE_REG_RX_HALT_BIT = 0;
   localparam int FIRST_MODE_REG_TX_HALT_BIT = 1;
   localparam int SECOND_MODE_REG_CLEAR_BIT = 1;
   localparam int IRQ_RX_TRIG_BIT = 3;
   localparam int IRQ_TX_TRIG_BIT = 4;
   localparam int IRQ_TX_EMPTY_BIT = 5;
   localparam int LSR_PARITY_BIT = 0;
   localparam int LSR_FRAME_BIT = 1;
   localparam int LSR_NOISE_BIT = 5;
   localparam int CFG_PAR_EN_BIT = 0;
   localparam int CFG_PAR_EVEN_BIT = 1;
   localparam int INV_RX_BIT = 4;
   localparam int INV_TX_BIT = 5;
   localparam int BAUD_RATE_LSB = 4;
   typedef enum logic [1:0] {
      RATE_STD = 2'b00,
      RATE_DBL = 2'b01,
      RATE_QUAD = 2'b10
   } quf_rate_type;
   // Sample ticks per bit minus one, and the index of the midbit sample.
   localparam logic [3:0] LAST_TICK_STD = 4'hF;
   localparam logic [3:0] MID_TICK_STD = 4'h8;
   localparam logic [3:0] LAST_TICK_DBL = 4'h7;
   localparam logic [3:0] MID_TICK_DBL = 4'h4;
   localparam logic [3:0] LAST_TICK_QUAD = 4'h3;
   localparam logic [3:0] MID_TICK_QUAD = 4'h2;
   localparam logic [2:0] LAST_DATA_BIT = 3'h7;
   typedef enum logic [2:0] {
      SER_IDLE = 3'b000,
      SER_START = 3'b001,
      SER_DATA = 3'b010,
      SER_PARITY = 3'b011,
      SER_STOP = 3'b100
   } quf_ser_state_type;
   typedef struct packed {
      logic noise;
      logic frame;
      logic parity;
      logic [7:0] data;
   } quf_rx_word_type;
endpackage : quf_pkg

// >>> test/quf_props.sv
`timescale 1ns/1ps
module quf_props (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] txd,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_wr; s_axi_awvalid && s_axi_wvalid && s_axi_awready |-> ##2 s_axi_bvalid; endproperty
   a_wr: assert property (p_wr) else $error("write unanswered");
   property p_bd; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
   a_bd: assert property (p_bd) else $error("write not closed");
   property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd: assert property (p_rd) else $error("read unanswered");
   property p_rn; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
   a_rn: assert property (p_rn) else $error("read not closed");
   property p_rw; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
   a_rw: assert property (p_rw) else $error("read wider than a byte");
   property p_bb; s_axi_bvalid |-> !s_axi_awready; endproperty
   a_bb: assert property (p_bb) else $error("write taken while busy");
   property p_id; $rose(rst_n) |-> txd == 4'hF; endproperty
   a_id: assert property (p_id) else $error("lines not idle");
   // A start bit lasts a whole bit time, far longer than eight clocks.
   property p_st; $fell(txd[0]) |=> !txd[0] [*8]; endproperty
   a_st: assert property (p_st) else $error("start bit too short");
endmodule : quf_props
bind quf_quad_uart quf_props u_props (.*);

// >>> test/quf_line_model.sv
`timescale 1ns/1ps
module quf_line_model (
   input wire logic [3:0] txd,
   output logic [3:0] rxd
);
   // One bit is sixteen sample ticks of 200 ns; the bench shortens it for the fast rate.
   int bitNs = 3200;
   logic [7:0] lastTx = 8'h00;
   int txCount = 0;
   initial rxd = 4'hF;
   always @(negedge txd[0]) begin
      #(bitNs / 2);
      for (int i = 0; i < 8; i++) #bitNs lastTx[i] = txd[0];
      #bitNs if (txd[0]) txCount++;
   end
   task automatic send(input int ch, input logic [7:0] b, input logic stopBit, input logic glitch);
      // Stay off the clock edges, so the input flops never race the model.
      #3 rxd[ch] = 1'b0;
      #bitNs;
      for (int i = 0; i < 8; i++) begin
         rxd[ch] = b[i];
         // The pulse is one tick long, so it spoils just one of the three votes.
         #(bitNs / 2 - 100) rxd[ch] = b[i] ^ (glitch && i == 0);
         #200 rxd[ch] = b[i];
         #(bitNs / 2 - 100);
      end
      rxd[ch] = stopBit;
      #bitNs rxd[ch] = 1'b1;
      #bitNs;
   endtask : send
endmodule : quf_line_model

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {logic wr; logic [7:0] a, d, q; logic [1:0] r;} quf_row_type;
   localparam logic [1:0] OK = quf_pkg::AXI_OKAY, ER = quf_pkg::AXI_SLVERR;
   logic clk = 1'b0, rst_n = 1'b0, sampleClk = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, aw, w, ar, done;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, q;
   logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [3:0] s_axi_wstrb = 4'hF, rxd, txd;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [7:0] rxExp [6] = '{8'h3C, 8'h00, 8'h5A, 8'h02, 8'h81, 8'h20};
   int num_errors = 0, num_checks = 0;
   quf_row_type rows [8] = '{'{1'b0, 8'h18, 8'h00, 8'h00, OK}, '{1'b0, 8'h10, 8'h00, 8'h00, OK},
      '{1'b1, 8'h54, 8'h21, 8'h00, OK}, '{1'b0, 8'h54, 8'h00, 8'h21, OK},
      '{1'b1, 8'hE4, 8'h20, 8'h00, OK}, '{1'b0, 8'hE4, 8'h00, 8'h20, OK},
      '{1'b0, 8'h2C, 8'h00, 8'h00, ER}, '{1'b1, 8'h06, 8'h05, 8'h00, ER}};
   always #12.5 clk = ~clk;
   always #100 sampleClk = ~sampleClk;
   quf_line_model lm (.*);
   quf_quad_uart dut (.*);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Handshakes are judged at the falling edge, where values of the coming rising edge are settled.
   task automatic bus(input logic wr, input logic [7:0] a, d, e);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_bready <= wr;
      s_axi_arvalid <= !wr;
      s_axi_rready <= !wr;
      done = 1'b0;
      while (done !== 1'b1) begin
         @(negedge clk);
         aw = s_axi_awready;
         w = s_axi_wready;
         ar = s_axi_arready;
         done = wr ? s_axi_bvalid : s_axi_rvalid;
         q = s_axi_rdata[7:0];
         r = wr ? s_axi_bresp : s_axi_rresp;
         @(posedge clk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (ar) s_axi_arvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      if (!wr) chk(q, e);
   endtask : bus
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         bus(rows[i].wr, rows[i].a, rows[i].d, rows[i].q);
         chk({6'h00, r}, {6'h00, rows[i].r});
      end
      bus(1'b1, 8'h00, 8'hA5, 8'h00);
      wait (lm.txCount == 1);
      chk(lm.lastTx, 8'hA5);
      bus(1'b0, 8'h10, 8'h00, 8'h20);
      // Channel 2 is halted, so written words stay queued; the queue takes 128 of the 130 writes.
      bus(1'b1, 8'h84, 8'h02, 8'h00);
      bus(1'b1, 8'h94, 8'h01, 8'h00);
      repeat (8) bus(1'b1, 8'h80, 8'h55, 8'h00);
      bus(1'b0, 8'h90, 8'h00, 8'h10);
      repeat (122) bus(1'b1, 8'h80, 8'hAA, 8'h00);
      bus(1'b0, 8'h98, 8'h00, 8'h80);
      chk({7'h00, txd[2]}, 8'h01);
      bus(1'b1, 8'h88, 8'h02, 8'h00);
      bus(1'b0, 8'h98, 8'h00, 8'h00);
      lm.send(1, 8'h3C, 1'b1, 1'b0);
      lm.send(1, 8'h5A, 1'b0, 1'b0);
      lm.send(1, 8'h81, 1'b1, 1'b1);
      bus(1'b0, 8'h5C, 8'h00, 8'h03);
      for (int i = 0; i < 6; i += 2) begin
         bus(1'b0, 8'h40, 8'h00, rxExp[i]);
         bus(1'b0, 8'h4C, 8'h00, rxExp[i + 1]);
      end
      bus(1'b0, 8'h40, 8'h00, 8'h00);
      bus(1'b1, 8'h44, 8'h01, 8'h00);
      lm.send(1, 8'h11, 1'b1, 1'b0);
      bus(1'b0, 8'h5C, 8'h00, 8'h00);
      // Channel 3 runs at the quadruple rate, four ticks per bit.
      lm.bitNs = 800;
      lm.send(3, 8'hC3, 1'b1, 1'b0);
      bus(1'b0, 8'hC0, 8'h00, 8'hC3);
      bus(1'b0, 8'hCC, 8'h00, 8'h00);
      bus(1'b1, 8'hE8, 8'h20, 8'h00);
      repeat (4) @(posedge clk);
      chk({7'h00, txd[3]}, 8'h00);
      // A second reset in mid-run must wipe the halt bit left on channel 1.
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, 8'h44, 8'h00, 8'h00);
      report_and_stop();
   end
   initial begin
      #1000000 num_errors++;
      report_and_stop();
   end
endmodule : tb_top
